// >>> logic/lmd_pkg.sv
// Contract
// - zero to reset command restores all defaults
// - eighteen channels modulated, four selectable resolutions
// - duty combines high and low byte
// - reset gives 8-bit, 62kHz from 16MHz
// - all channel periods start together
// - osc and resolution fields set frequency
// - 00 to 10/11 captures short/open status
// - spread range selects 5/15/24/34 percent
// - shutdown keeps every register unchanged
// - soft shutdown bit zero blanks outputs
// - soft shutdown keeps registers accessible
// - pin low holds hardware shutdown
// - pin rising edge resets serial logic
// - hardware shutdown still accepts register access
// - two scale bytes set each channel current
// - zero to update register loads duties outside hardware and soft shutdown
// - scale writes act immediately
package lmd_pkg;

    localparam int NUM_CHAN = 18;
    localparam int DUTY_BYTES = 72;
    localparam int SCALE_BYTES = 36;

    // register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DUTY_FIRST = 8'h01;
    localparam logic [7:0] ADDR_DUTY_LAST = 8'h48;
    localparam logic [7:0] ADDR_UPDATE = 8'h49;
    localparam logic [7:0] ADDR_SCALE_FIRST = 8'h4a;
    localparam logic [7:0] ADDR_SCALE_LAST = 8'h6d;
    localparam logic [7:0] ADDR_GAIN = 8'h6e;
    localparam logic [7:0] ADDR_FAULT_SEL = 8'h71;
    localparam logic [7:0] ADDR_FAULT_FIRST = 8'h72;
    localparam logic [7:0] ADDR_FAULT_LAST = 8'h76;
    localparam logic [7:0] ADDR_SPREAD = 8'h78;
    localparam logic [7:0] ADDR_RESET = 8'h7f;

    // command value that triggers reset and update
    localparam logic [7:0] CMD_GO = 8'h00;

    // main control fields
    localparam int CTRL_SSD_BIT = 0;
    localparam int CTRL_RES_LSB = 1;
    localparam int CTRL_OSC_LSB = 4;

    // spread spectrum fields
    localparam int SPR_CLT_LSB = 0;
    localparam int SPR_RNG_LSB = 2;
    localparam int SPR_SSP_BIT = 4;
    localparam int SPR_DC_LSB = 5;

    // fault select codes
    localparam logic [1:0] FDS_IDLE = 2'h0;
    localparam logic [1:0] FDS_SHORT = 2'h2;
    localparam logic [1:0] FDS_OPEN = 2'h3;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] SPREAD_RESET = 8'h00;

    // oscillator enable from the fast clock, fractional step
    localparam int CLK_MHZ = 250;
    localparam int OSC_MHZ = 16;
    localparam logic [7:0] ACC_STEP = 8'(OSC_MHZ);
    localparam logic [7:0] ACC_WRAP = 8'(CLK_MHZ);

    // resolution code to counter terminal value
    function automatic logic [15:0] res_max(input logic [1:0] sel);
        case (sel)
            2'h0: res_max = 16'h00ff;
            2'h1: res_max = 16'h03ff;
            2'h2: res_max = 16'h0fff;
            default: res_max = 16'hffff;
        endcase
    endfunction

    // spread range code to percent
    function automatic logic [5:0] spread_pct(input logic [1:0] spread_range);
        case (spread_range)
            2'h0: spread_pct = 6'h05;
            2'h1: spread_pct = 6'h0f;
            2'h2: spread_pct = 6'h18;
            default: spread_pct = 6'h22;
        endcase
    endfunction

endpackage

// >>> logic/lmd_pwm_channel.sv
module lmd_pwm_channel
    import lmd_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // shared period counter
    input  wire logic [15:0] pwmCount,
    input  wire logic [1:0]  resolutionSel,
    // channel settings
    input  wire logic [15:0] dutyA,
    input  wire logic [15:0] dutyB,
    input  wire logic        dcFull,
    input  wire logic        driveEnable,
    // drive
    output logic             chanOut
);

    logic [16:0] dutySum;
    logic [15:0] dutyLim;
    logic [15:0] limit;
    logic        chanNext;

    // two duty pairs add, clamped to the resolution's top step
    always_comb begin
        limit = res_max(resolutionSel);
        dutySum = {1'b0, dutyA} + {1'b0, dutyB};
        dutyLim = (dutySum > {1'b0, limit}) ? limit : dutySum[15:0];
        // on from count zero: every channel rises together
        chanNext = driveEnable
            & (dcFull | (pwmCount < dutyLim));
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chanOut <= 1'b0;
        end else begin
            chanOut <= chanNext;
        end
    end

endmodule

// >>> logic/lmd_led_control.sv
module lmd_led_control
    import lmd_pkg::*;
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // decoded register access from the serial port
    input  wire logic                    regWrite,
    input  wire logic                    regRead,
    input  wire logic [7:0]              regAddr,
    input  wire logic [7:0]              regWrData,
    output logic [7:0]                   regRdData,
    // pins and analog status
    input  wire logic                    shutdownPinN,
    input  wire logic [NUM_CHAN-1:0]     shortSense,
    input  wire logic [NUM_CHAN-1:0]     openSense,
    // channel drive and analog settings
    output logic [NUM_CHAN-1:0]          channelOutput,
    output logic [NUM_CHAN*9-1:0]        channelCurrent,
    output logic [7:0]                   globalGain,
    output logic                         spreadEnable,
    output logic [1:0]                   spreadRange,
    output logic [5:0]                   spreadPct,
    output logic [1:0]                   spreadCycle,
    output logic                         analogEnable,
    output logic                         serialReset
);

    // register file
    logic [7:0]          ctrl_reg, ctrl_next;
    logic [7:0]          duty_reg [DUTY_BYTES];
    logic [7:0]          duty_next [DUTY_BYTES];
    logic [7:0]          act_reg [DUTY_BYTES];
    logic [7:0]          act_next [DUTY_BYTES];
    logic [7:0]          scale_reg [SCALE_BYTES];
    logic [7:0]          scale_next [SCALE_BYTES];
    logic [7:0]          gain_reg, gain_next;
    logic [1:0]          fds_reg, fds_next;
    logic [NUM_CHAN-1:0] fault_reg, fault_next;
    logic [7:0]          spread_reg, spread_next;
    logic [7:0]          rd_reg, rd_next;

    logic       resetCmd;
    logic       updateCmd;
    logic       updateOk;
    logic       pin_reg;
    logic [6:0] dutyIdx;
    logic [5:0] scaleIdx;
    logic [2:0] faultIdx;

    // decode of the access in flight
    always_comb begin
        dutyIdx = 7'(regAddr - ADDR_DUTY_FIRST);
        scaleIdx = 6'(regAddr - ADDR_SCALE_FIRST);
        faultIdx = 3'(regAddr - ADDR_FAULT_FIRST);
        resetCmd = regWrite && regAddr == ADDR_RESET
            && regWrData == CMD_GO;
        updateCmd = regWrite && regAddr == ADDR_UPDATE
            && regWrData == CMD_GO;
        updateOk = updateCmd && pin_reg && ctrl_reg[CTRL_SSD_BIT];
    end

    // writes never look at shutdown state, so both modes keep access; only the update load needs pin high and bit zero set
    always_comb begin
        ctrl_next = ctrl_reg;
        gain_next = gain_reg;
        fds_next = fds_reg;
        fault_next = fault_reg;
        spread_next = spread_reg;
        for (int i = 0; i < DUTY_BYTES; i++) begin
            duty_next[i] = duty_reg[i];
            act_next[i] = updateOk ? duty_reg[i] : act_reg[i];
        end
        for (int i = 0; i < SCALE_BYTES; i++) begin
            scale_next[i] = scale_reg[i];
        end
        if (resetCmd) begin
            ctrl_next = CTRL_RESET;
            gain_next = BYTE_RESET;
            fds_next = FDS_IDLE;
            fault_next = '0;
            spread_next = SPREAD_RESET;
            for (int i = 0; i < DUTY_BYTES; i++) begin
                duty_next[i] = BYTE_RESET;
                act_next[i] = BYTE_RESET;
            end
            for (int i = 0; i < SCALE_BYTES; i++) begin
                scale_next[i] = BYTE_RESET;
            end
        end else if (regWrite) begin
            if (regAddr == ADDR_CTRL) begin
                ctrl_next = regWrData;
            end
            if (regAddr >= ADDR_DUTY_FIRST && regAddr <= ADDR_DUTY_LAST) begin
                duty_next[dutyIdx] = regWrData;
            end
            if (regAddr >= ADDR_SCALE_FIRST
                && regAddr <= ADDR_SCALE_LAST) begin
                scale_next[scaleIdx] = regWrData;
            end
            if (regAddr == ADDR_GAIN) begin
                gain_next = regWrData;
            end
            if (regAddr == ADDR_SPREAD) begin
                spread_next = regWrData;
            end
            if (regAddr == ADDR_FAULT_SEL) begin
                fds_next = regWrData[1:0];
                // capture only on the step away from idle
                if (fds_reg == FDS_IDLE && regWrData[1:0] == FDS_SHORT) begin
                    fault_next = shortSense;
                end
                if (fds_reg == FDS_IDLE && regWrData[1:0] == FDS_OPEN) begin
                    fault_next = openSense;
                end
            end
        end
    end

    // read path, registered one cycle after the request
    always_comb begin
        rd_next = rd_reg;
        if (regRead) begin
            rd_next = 8'h00;
            if (regAddr == ADDR_CTRL) begin
                rd_next = ctrl_reg;
            end
            if (regAddr >= ADDR_DUTY_FIRST && regAddr <= ADDR_DUTY_LAST) begin
                rd_next = duty_reg[dutyIdx];
            end
            if (regAddr >= ADDR_SCALE_FIRST
                && regAddr <= ADDR_SCALE_LAST) begin
                rd_next = scale_reg[scaleIdx];
            end
            if (regAddr == ADDR_GAIN) begin
                rd_next = gain_reg;
            end
            if (regAddr == ADDR_FAULT_SEL) begin
                rd_next = {6'h00, fds_reg};
            end
            if (regAddr >= ADDR_FAULT_FIRST
                && regAddr <= ADDR_FAULT_LAST) begin
                // four channels a byte, status on the odd bits
                for (int b = 0; b < 4; b++) begin
                    if (int'(faultIdx) * 4 + b < NUM_CHAN) begin
                        rd_next[2*b+1] = fault_reg[int'(faultIdx) * 4 + b];
                    end
                end
            end
            if (regAddr == ADDR_SPREAD) begin
                rd_next = spread_reg;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            gain_reg <= BYTE_RESET;
            fds_reg <= FDS_IDLE;
            fault_reg <= '0;
            spread_reg <= SPREAD_RESET;
            rd_reg <= 8'h00;
            for (int i = 0; i < DUTY_BYTES; i++) begin
                duty_reg[i] <= BYTE_RESET;
                act_reg[i] <= BYTE_RESET;
            end
            for (int i = 0; i < SCALE_BYTES; i++) begin
                scale_reg[i] <= BYTE_RESET;
            end
        end else begin
            ctrl_reg <= ctrl_next;
            gain_reg <= gain_next;
            fds_reg <= fds_next;
            fault_reg <= fault_next;
            spread_reg <= spread_next;
            rd_reg <= rd_next;
            for (int i = 0; i < DUTY_BYTES; i++) begin
                duty_reg[i] <= duty_next[i];
                act_reg[i] <= act_next[i];
            end
            for (int i = 0; i < SCALE_BYTES; i++) begin
                scale_reg[i] <= scale_next[i];
            end
        end
    end

    // timebase: 16MHz enable, prescaler, shared period counter
    logic [7:0]  acc_reg, acc_next;
    logic [2:0]  pre_reg, pre_next;
    logic [15:0] cnt_reg, cnt_next;
    logic        oscTick;
    logic [8:0]  accSum;
    logic [1:0]  resSel;
    logic [2:0]  oscSel;

    always_comb begin
        resSel = ctrl_reg[CTRL_RES_LSB +: 2];
        oscSel = ctrl_reg[CTRL_OSC_LSB +: 3];
        // fractional accumulator: 250 is no multiple of 16, and the
        // sum needs a ninth bit or it wraps before it reaches 250
        accSum = {1'b0, acc_reg} + {1'b0, ACC_STEP};
        oscTick = accSum >= {1'b0, ACC_WRAP};
        acc_next = oscTick ? 8'(accSum - {1'b0, ACC_WRAP}) : accSum[7:0];
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        if (oscTick) begin
            // divide by osc_select+1, then by the resolution period
            if (pre_reg >= oscSel) begin
                pre_next = 3'h0;
                cnt_next = (cnt_reg >= res_max(resSel))
                    ? 16'h0000 : 16'(cnt_reg + 16'h0001);
            end else begin
                pre_next = 3'(pre_reg + 3'h1);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_reg <= 8'h00;
            pre_reg <= 3'h0;
            cnt_reg <= 16'h0000;
        end else begin
            acc_reg <= acc_next;
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
        end
    end

    // shutdown pin, edge detect and analog settings
    logic                  serial_next;
    logic [NUM_CHAN*9-1:0] current_next;
    logic                  driveOn;

    always_comb begin
        serial_next = shutdownPinN & ~pin_reg;
        driveOn = pin_reg & ctrl_reg[CTRL_SSD_BIT];
        for (int c = 0; c < NUM_CHAN; c++) begin
            current_next[c*9 +: 9] = {1'b0, scale_reg[2*c]}
                + {1'b0, scale_reg[2*c+1]};
        end
    end

    // hardware shutdown gates drive and analog enable, soft shutdown gates drive only; register contents stay put
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_reg <= 1'b1; // pin idles high, no edge out of reset
            serialReset <= 1'b0;
            analogEnable <= 1'b0;
            channelCurrent <= '0;
            globalGain <= 8'h00;
            spreadEnable <= 1'b0;
            spreadRange <= 2'h0;
            spreadPct <= 6'h00;
            spreadCycle <= 2'h0;
        end else begin
            pin_reg <= shutdownPinN;
            serialReset <= serial_next;
            analogEnable <= shutdownPinN;
            channelCurrent <= current_next;
            globalGain <= gain_reg;
            spreadEnable <= spread_reg[SPR_SSP_BIT];
            spreadRange <= spread_reg[SPR_RNG_LSB +: 2];
            spreadPct <= spread_pct(spread_reg[SPR_RNG_LSB +: 2]);
            spreadCycle <= spread_reg[SPR_CLT_LSB +: 2];
        end
    end

    assign regRdData = rd_reg;

    // one comparator per channel off the shared counter
    generate
        for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
            lmd_pwm_channel u_chan (
                .ref_clk       (ref_clk),
                .rst           (rst),
                .pwmCount      (cnt_reg),
                .resolutionSel (resSel),
                .dutyA         ({act_reg[4*c+1], act_reg[4*c]}),
                .dutyB         ({act_reg[4*c+3], act_reg[4*c+2]}),
                .dcFull        (spread_reg[SPR_DC_LSB + c / 6]),
                .driveEnable   (driveOn),
                .chanOut       (channelOutput[c])
            );
        end
    endgenerate

    // checks
    sequence s_short_arm;
        regWrite && regAddr == ADDR_FAULT_SEL && fds_reg == FDS_IDLE
            && regWrData[1:0] == FDS_SHORT;
    endsequence

    sequence s_update_ok;
        updateCmd && pin_reg && ctrl_reg[CTRL_SSD_BIT];
    endsequence

    a_reset_cmd: assert property (@(posedge ref_clk) disable iff (rst)
        resetCmd |=> ctrl_reg == CTRL_RESET && gain_reg == BYTE_RESET
            && scale_reg[0] == BYTE_RESET && act_reg[0] == BYTE_RESET)
        else $error("reset command left a register set");
    a_reset_nonzero: assert property (@(posedge ref_clk)
        disable iff (rst)
        regWrite && regAddr == ADDR_RESET && regWrData != CMD_GO
            |=> $stable(gain_reg) && $stable(ctrl_reg))
        else $error("nonzero reset write changed state");
    a_update_copy: assert property (@(posedge ref_clk) disable iff (rst)
        s_update_ok |=> act_reg[0] == $past(duty_reg[0]))
        else $error("update did not load duty");
    // the reset command may also clear active duties
    a_update_block: assert property (@(posedge ref_clk)
        disable iff (rst)
        !updateOk && !resetCmd |=> $stable(act_reg[0]))
        else $error("duty changed without update");
    a_scale_now: assert property (@(posedge ref_clk) disable iff (rst)
        regWrite && regAddr == ADDR_SCALE_FIRST && !resetCmd
            |=> scale_reg[0] == $past(regWrData) ##1 channelCurrent[8:0]
            == 9'({1'b0, $past(scale_reg[0])} + {1'b0, $past(scale_reg[1])}))
        else $error("scale write not applied at once");
    a_soft_blank: assert property (@(posedge ref_clk) disable iff (rst)
        !ctrl_reg[CTRL_SSD_BIT] |=> channelOutput == '0)
        else $error("output on in soft shutdown");
    a_hw_blank: assert property (@(posedge ref_clk) disable iff (rst)
        !pin_reg && !shutdownPinN |=> channelOutput == '0 && !analogEnable)
        else $error("output on in hardware shutdown");
    a_pin_edge: assert property (@(posedge ref_clk) disable iff (rst)
        shutdownPinN && !pin_reg |=> serialReset ##1 !serialReset)
        else $error("serial reset pulse wrong");
    a_short_grab: assert property (@(posedge ref_clk) disable iff (rst)
        s_short_arm |=> fault_reg == $past(shortSense))
        else $error("short status not captured");
    a_range_pct: assert property (@(posedge ref_clk) disable iff (rst)
        spread_reg[SPR_RNG_LSB +: 2] == 2'h3 |=> spreadPct == 6'h22)
        else $error("spread percent wrong");

endmodule

// >>> sim/lmd_host_model.sv
module lmd_host_model
    import lmd_pkg::*;
(
    // clock
    input  wire logic       ref_clk,
    // register port toward the device
    output logic            regWrite,
    output logic            regRead,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData,
    input  wire logic [7:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle port at time zero
    initial begin
        regWrite  = 1'b0;
        regRead   = 1'b0;
        regAddr   = 8'h00;
        regWrData = 8'h00;
    end

    // one strobe per byte; released lines are inverted so stale data
    // can never be mistaken for a fresh access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr   = a;
        regWrData = d;
        regWrite  = 1'b1;
        @(negedge ref_clk);
        regWrite  = 1'b0;
        regAddr   = ~a;
        regWrData = ~d;
    endtask

    // data is taken one full cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge ref_clk);
        regRead = 1'b0;
        regAddr = ~a;
        @(negedge ref_clk);
        d = regRdData;
    endtask

    // gain forced to one first, else the captured status is meaningless
    task automatic detect(input logic [1:0] code);
        wr(ADDR_GAIN, 8'h01);
        wr(ADDR_FAULT_SEL, {6'h00, code});
    endtask

    // five result bytes, channel 1 in the low byte
    task automatic read_faults(output logic [39:0] r);
        logic [7:0] b;
        for (int k = 0; k < 5; k++) begin
            rd(ADDR_FAULT_FIRST + 8'(k), b);
            r[k*8+:8] = b;
        end
    endtask
endmodule

// >>> sim/tb.sv
module tb
    import lmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic               ref_clk;
    logic               rst;
    logic               regWrite;
    logic               regRead;
    logic [7:0]         regAddr;
    logic [7:0]         regWrData;
    logic [7:0]         regRdData;
    logic               shutdownPinN;
    logic [17:0]        shortSense;
    logic [17:0]        openSense;
    logic [17:0]        channelOutput;
    logic [161:0]       channelCurrent;
    logic [7:0]         globalGain;
    logic               spreadEnable;
    logic [1:0]         spreadRange;
    logic [5:0]         spreadPct;
    logic [1:0]         spreadCycle;
    logic               analogEnable;
    logic               serialReset;
    logic [7:0]         rdv;
    logic [39:0]        flt;
    logic               sync;
    int                 per;
    int                 hi;
    int                 errors = 0;
    int                 checked = 0;

    localparam logic [5:0] PCT [4] = '{6'h05, 6'h0f, 6'h18, 6'h22};

    lmd_led_control u_dut (
        .ref_clk(ref_clk), .rst(rst), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .shutdownPinN(shutdownPinN),
        .shortSense(shortSense), .openSense(openSense),
        .channelOutput(channelOutput), .channelCurrent(channelCurrent),
        .globalGain(globalGain), .spreadEnable(spreadEnable),
        .spreadRange(spreadRange), .spreadPct(spreadPct),
        .spreadCycle(spreadCycle), .analogEnable(analogEnable),
        .serialReset(serialReset)
    );

    lmd_host_model u_host (
        .ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData)
    );

    // 250 MHz
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, rdv);
        check(40'(rdv), 40'(exp));
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // status bit of channel c sits at odd bit of byte c/4
    function automatic logic [39:0] fexp(input logic [17:0] s);
        fexp = '0;
        for (int c = 0; c < 18; c++)
            fexp[(c/4)*8+(c%4)*2+1] = s[c];
    endfunction

    // one full period of channel 1, rise to rise, with its high time
    task automatic measure();
        logic prev;
        logic rise;
        logic started;
        prev = 1'b1;
        started = 1'b0;
        per = 0;
        hi = 0;
        for (int n = 0; n < 140000; n++) begin
            @(negedge ref_clk);
            rise = prev === 1'b0 && channelOutput[0] === 1'b1;
            prev = channelOutput[0];
            if (rise && started)
                break;
            if (rise) begin
                started = 1'b1;
                sync = channelOutput[17];
            end
            if (started) begin
                per++;
                hi += int'(channelOutput[0] === 1'b1);
            end
        end
    endtask

    // outputs must stay dark for longer than a default period
    task automatic quiet();
        int n;
        n = 0;
        repeat (4100) begin
            @(negedge ref_clk);
            if (channelOutput !== 18'h0)
                n++;
        end
        check(40'(n), 40'h0);
    endtask

    // about 90k cycles: all measured periods together stay below this
    initial begin
        #360000;
        errors++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        shutdownPinN = 1'b1;
        shortSense = 18'h0;
        openSense = 18'h0;
        idle(16);
        rst = 1'b0;
        // defaults after reset
        rdchk(ADDR_CTRL, 8'h00);
        rdchk(8'h01, 8'h00);
        rdchk(ADDR_GAIN, 8'h00);
        rdchk(ADDR_SPREAD, 8'h00);
        // scale bytes act at once, no update command
        u_host.wr(8'h4a, 8'h80);
        u_host.wr(8'h4b, 8'h80);
        u_host.wr(8'h4c, 8'hff);
        u_host.wr(8'h4d, 8'hff);
        idle(2);
        check(40'(channelCurrent[8:0]), 40'h100);
        check(40'(channelCurrent[17:9]), 40'h1fe);
        rdchk(8'h4c, 8'hff);
        // every spread range code
        for (int r = 0; r < 4; r++) begin
            u_host.wr(ADDR_SPREAD, {3'h0, 1'b1, 2'(r), 2'h2});
            idle(2);
            check(40'({spreadEnable, spreadRange, spreadPct, spreadCycle}),
                  40'({1'b1, 2'(r), PCT[r], 2'h2}));
        end
        // short capture, open capture, then a change not from idle
        shortSense = 18'h2a5c3;
        u_host.detect(FDS_SHORT);
        u_host.read_faults(flt);
        check(flt, fexp(shortSense));
        u_host.wr(ADDR_FAULT_SEL, 8'h00);
        openSense = 18'h15a3c;
        u_host.detect(FDS_OPEN);
        u_host.read_faults(flt);
        check(flt, fexp(openSense));
        shortSense = 18'h3ffff;
        u_host.detect(FDS_SHORT);
        u_host.wr(ADDR_FAULT_FIRST, 8'hff);
        u_host.read_faults(flt);
        check(flt, fexp(openSense));
        // duties held back until the update command
        u_host.wr(ADDR_CTRL, 8'h01);
        u_host.wr(8'h01, 8'h04);
        u_host.wr(8'h02, 8'h00);
        u_host.wr(8'h45, 8'h08);
        quiet();
        u_host.wr(ADDR_UPDATE, CMD_GO);
        measure();
        check(40'(per), 40'd4000);
        check(40'(hi >= 61 && hi <= 64), 40'h1);
        check(40'(sync), 40'h1);
        // a nonzero update value must not load the new duty
        u_host.wr(8'h01, 8'h10);
        u_host.wr(ADDR_UPDATE, 8'h01);
        measure();
        check(40'(hi >= 61 && hi <= 64), 40'h1);
        // resolution and divider set the period
        u_host.wr(ADDR_CTRL, 8'h03);
        measure();
        check(40'(per), 40'd16000);
        u_host.wr(ADDR_CTRL, 8'h11);
        measure();
        check(40'(per), 40'd8000);
        // first group forced fully on, second group still from duties
        u_host.wr(ADDR_SPREAD, 8'h20);
        idle(2);
        check(40'(channelOutput[11:0]), 40'h03f);
        // soft shutdown blanks, registers stay usable
        u_host.wr(ADDR_CTRL, 8'h00);
        idle(2);
        quiet();
        u_host.wr(ADDR_GAIN, 8'h44);
        rdchk(ADDR_GAIN, 8'h44);
        check(40'(globalGain), 40'h44);
        // hardware shutdown and pin release
        shutdownPinN = 1'b0;
        idle(2);
        check(40'(analogEnable), 40'h0);
        u_host.wr(ADDR_GAIN, 8'h33);
        rdchk(ADDR_GAIN, 8'h33);
        shutdownPinN = 1'b1;
        hi = 0;
        repeat (6) begin
            @(negedge ref_clk);
            hi += int'(serialReset === 1'b1);
        end
        check(40'(hi), 40'h1);
        check(40'(analogEnable), 40'h1);
        rdchk(ADDR_GAIN, 8'h33);
        // reset command: nonzero ignored, zero restores defaults
        u_host.wr(ADDR_RESET, 8'h01);
        rdchk(ADDR_GAIN, 8'h33);
        rdchk(ADDR_RESET, 8'h00);
        u_host.wr(ADDR_RESET, CMD_GO);
        idle(2);
        rdchk(ADDR_GAIN, 8'h00);
        rdchk(8'h4c, 8'h00);
        rdchk(ADDR_SPREAD, 8'h00);
        check(40'(channelCurrent[17:0]), 40'h0);
        report_and_stop();
    end
endmodule
